/* File: rtl/trap_inst_pkg.sv */
// constants, types and carriers shared by the trap instruction unit
// assumes one core clock; all producers of the carriers sit on that clock
package trap_inst_pkg;

  // ==========================================================================
  // instruction encoding
  localparam logic [6:0] OP_LOAD     = 7'h03;
  localparam logic [6:0] OP_LOAD_FP  = 7'h07;
  localparam logic [6:0] OP_STORE    = 7'h23;
  localparam logic [6:0] OP_STORE_FP = 7'h27;
  localparam logic [6:0] OP_AMO      = 7'h2F;
  localparam logic [6:0] OP_SYSTEM   = 7'h73;
  localparam logic [2:0] F3_PRIV     = 3'h0;
  localparam logic [2:0] F3_GUEST    = 3'h4;
  localparam logic [3:0] F7_GUEST_HI = 4'h6;
  localparam logic [6:0] F7_SUPER_RET   = 7'h08;
  localparam logic [6:0] F7_MACHINE_RET = 7'h18;
  localparam logic [4:0] RS2_RET     = 5'h02;
  localparam logic [2:0] F3_WORD     = 3'h2;
  localparam logic [2:0] F3_DOUBLE   = 3'h3;
  localparam logic [1:0] C_QUAD0     = 2'h0;
  localparam logic [1:0] C_QUAD2     = 2'h2;

  // ==========================================================================
  // pseudoinstruction codes
  localparam logic [31:0] PSEUDO_RD32 = 32'h0000_2000;
  localparam logic [31:0] PSEUDO_WR32 = 32'h0000_2020;
  localparam logic [31:0] PSEUDO_RD64 = 32'h0000_3000;
  localparam logic [31:0] PSEUDO_WR64 = 32'h0000_3020;

  // ==========================================================================
  // exception causes with a defined transformation
  localparam logic [5:0] CS_LD_MISAL  = 6'h04;
  localparam logic [5:0] CS_LD_ACC    = 6'h05;
  localparam logic [5:0] CS_ST_MISAL  = 6'h06;
  localparam logic [5:0] CS_ST_ACC    = 6'h07;
  localparam logic [5:0] CS_LD_PAGE   = 6'h0D;
  localparam logic [5:0] CS_ST_PAGE   = 6'h0F;
  localparam logic [5:0] CS_IF_GPAGE  = 6'h14;
  localparam logic [5:0] CS_LD_GPAGE  = 6'h15;
  localparam logic [5:0] CS_ST_GPAGE  = 6'h17;

  // ==========================================================================
  // register map, byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MEPC   = 8'h08;
  localparam logic [7:0] OFS_SEPC   = 8'h0C;
  localparam logic [7:0] OFS_VSEPC  = 8'h10;
  localparam logic [7:0] OFS_MTINST = 8'h14;
  localparam logic [7:0] OFS_HTINST = 8'h18;
  localparam int         CTRL_WIDE64  = 0;
  localparam int         CTRL_AD_UPD  = 1;
  localparam logic [1:0] CTRL_RESET   = 2'h0;
  localparam logic [31:0] EPC_RESET   = 32'h0000_0000;
  localparam logic [31:0] TINST_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {PRIV_U = 2'h0, PRIV_S = 2'h1, PRIV_M = 2'h3} priv_t;
  typedef enum logic [1:0] {TGT_M, TGT_HS, TGT_VS} target_t;

  // status copy, bit 0 is priv[0]
  typedef struct packed {
    logic  vs_spp;
    logic  vs_super_prev_irq_enable;
    logic  vs_sie;
    logic  hyp_saved_virt;
    logic  super_prev_priv;
    logic  super_prev_irq_enable;
    logic  super_irq_enable;
    logic  machine_prev_virt;
    priv_t machine_prev_priv;
    logic  machine_prev_irq_enable;
    logic  machine_irq_enable;
    logic  virt;
    priv_t priv;
  } status_t;
  localparam status_t STATUS_RESET = '{priv: PRIV_M, machine_prev_priv: PRIV_U, default: 1'h0};

  typedef struct packed {
    logic        valid;
    logic        interrupt;
    logic [5:0]  cause;
    target_t     target;
    logic        compressed;
    logic [31:0] insn;
    logic [31:0] fault_va;
    logic [31:0] orig_va;
    logic        implicit_gs;
    logic        gpa_nonzero;
    logic        ad_update;
  } trap_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] insn;
  } ret_req_t;

endpackage

/* File: rtl/trap_c_expand.sv */
// expands compressed memory instructions to full length, immediates zero
// assumes the caller replaces rs1 and needs no immediate
`timescale 1ns/1ps
module trap_c_expand import trap_inst_pkg::*; #(
  parameter bit RV64 = 1'h0
) (
  input  wire logic [15:0] insn16_i,
  output logic      [31:0] insn32_o,
  output logic             valid_o
);
  logic [1:0] quad;
  logic [2:0] cf3;
  logic       is_store;
  logic [4:0] reg_fld;
  logic [2:0] mem_f3;
  logic       fp;
  logic [6:0] mem_op;

  assign quad     = insn16_i[1:0];
  assign cf3      = insn16_i[15:13];
  assign is_store = cf3[2];
  assign reg_fld  = (quad == C_QUAD0) ? {2'h1, insn16_i[4:2]}
                  : (is_store ? insn16_i[6:2] : insn16_i[11:7]);
  // 001 double fp, 010 word, 011 double int on 64-bit else single fp
  assign fp       = (cf3[1:0] == 2'h1) | ((cf3[1:0] == 2'h3) & ~RV64);
  assign mem_f3   = (cf3[1:0] == 2'h2 || (cf3[1:0] == 2'h3 && !RV64)) ? F3_WORD : F3_DOUBLE;
  assign mem_op   = is_store ? (fp ? OP_STORE_FP : OP_STORE) : (fp ? OP_LOAD_FP : OP_LOAD);
  assign valid_o  = (quad == C_QUAD0 || quad == C_QUAD2) && cf3[1:0] != 2'h0;
  assign insn32_o = !valid_o ? 32'h0
                  : is_store ? {7'h00, reg_fld, 5'h00, mem_f3, 5'h00, mem_op}
                  : {12'h000, 5'h00, mem_f3, reg_fld, mem_op};
endmodule // trap_c_expand

/* File: rtl/trap_xform.sv */
// transforms a full-length trapping memory instruction for the tinst value
// assumes offset already reduced to five bits
`timescale 1ns/1ps
module trap_xform import trap_inst_pkg::*; (
  input  wire logic [31:0] insn_i,
  input  wire logic [4:0]  offset_i,
  output logic      [31:0] value_o
);
  logic [6:0] op;
  logic       is_load;
  logic       is_store;
  logic       is_amo;
  logic       is_guest;

  assign op       = insn_i[6:0];
  assign is_load  = (op == OP_LOAD) || (op == OP_LOAD_FP);
  assign is_store = (op == OP_STORE) || (op == OP_STORE_FP);
  assign is_amo   = (op == OP_AMO);
  assign is_guest = (op == OP_SYSTEM) && (insn_i[14:12] == F3_GUEST)
                  && (insn_i[31:28] == F7_GUEST_HI);
  assign value_o  =
      is_load  ? {12'h000, offset_i, insn_i[14:0]} :
      is_store ? {7'h00, insn_i[24:20], offset_i, insn_i[14:12], 5'h00, op} :
      is_amo   ? {insn_i[31:20], offset_i, insn_i[14:0]} :
      is_guest ? {insn_i[31:20], offset_i, insn_i[14:0]} :
      32'h0;
endmodule // trap_xform

/* File: rtl/trap_inst_unit.sv */
// trap instruction value builder and trap-return sequencer, wishbone slave
// assumes trap and return requests come from core logic on clk_i
//
// What this block does
// - atomic keeps all fields, offset in rs1
// - guest load/store keeps fields, offset in rs1
// - offset is fault address minus original
// - basic load/store immediates forced zero
// - compressed expanded, transformed, bit 1 cleared
// - low bits 01 compressed, 11 otherwise
// - implicit guest translation fault writes pseudo code
// - 32-bit guest width uses 2000/2020
// - 64-bit guest width uses 3000/3020
// - write code only for A/D update
// - trap instruction registers hold real state
// - machine return restores stack and pc
// - super return with virt off restores
// - super return in guest updates guest copy
// - returns decoded by system opcode fields
// - interrupt trap writes zero
// - untransformed synchronous trap writes zero
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module trap_inst_unit import trap_inst_pkg::*; #(
  parameter bit CORE_RV64 = 1'h0
) (
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic      wb_we_i,
  input  wire logic      wb_cyc_i,
  input  wire logic      wb_stb_i,
  output logic [31:0]    wb_dat_o,
  output logic           wb_ack_o,
  input  wire trap_req_t trap_i,
  input  wire ret_req_t  ret_i,
  output logic [31:0]    mtinst_o,
  output logic [31:0]    htinst_o,
  output logic           mtinst_we_o,
  output logic           htinst_we_o,
  output status_t        status_o,
  output logic           redirect_o,
  output logic [31:0]    redirect_pc_o
);

  // ==========================================================================
  // state
  logic [1:0]  ctrl;
  logic [31:0] mepc;
  logic [31:0] sepc;
  logic [31:0] vsepc;
  status_t     status;
  status_t     next_status;
  logic [31:0] next_tinst;
  logic [31:0] next_rdata;
  logic        next_redirect;
  logic [31:0] next_pc;

  // ==========================================================================
  // wishbone decode
  logic        wb_req;
  logic        wb_wr;
  logic        hit_ctrl;
  logic        hit_status;
  logic        hit_mepc;
  logic        hit_sepc;
  logic        hit_vsepc;
  logic        hit_mtinst;
  logic        hit_htinst;

  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where the master samples ack high
  assign wb_wr      = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign hit_ctrl   = wb_adr_i == OFS_CTRL;
  assign hit_status = wb_adr_i == OFS_STATUS;
  assign hit_mepc   = wb_adr_i == OFS_MEPC;
  assign hit_sepc   = wb_adr_i == OFS_SEPC;
  assign hit_vsepc  = wb_adr_i == OFS_VSEPC;
  assign hit_mtinst = wb_adr_i == OFS_MTINST;
  assign hit_htinst = wb_adr_i == OFS_HTINST;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  logic [31:0] status_word;
  logic [31:0] status_wr;
  logic [31:0] ctrl_wr;
  assign ctrl_wr     = merge({30'h0, ctrl}, wb_dat_i, wb_sel_i);
  assign status_word = {17'h00000, status};
  assign status_wr   = merge(status_word, wb_dat_i, wb_sel_i);

  // unmapped offsets answer with zero
  assign next_rdata = hit_ctrl   ? {30'h0, ctrl} :
                      hit_status ? status_word :
                      hit_mepc   ? mepc :
                      hit_sepc   ? sepc :
                      hit_vsepc  ? vsepc :
                      hit_mtinst ? mtinst_o :
                      hit_htinst ? htinst_o : 32'h0;

  // ==========================================================================
  // trap instruction value
  logic [31:0] exp_insn;
  logic        exp_ok;
  logic [31:0] full_insn;
  logic [31:0] addr_diff;
  logic [4:0]  addr_off;
  logic [31:0] xf_val;
  logic [31:0] std_val;
  logic        mem_cause;
  logic        gpage_cause;
  logic        pseudo_case;
  logic        pseudo_write;
  logic [31:0] pseudo_val;
  logic        trap_m;
  logic        trap_hs;

  trap_c_expand #(.RV64(CORE_RV64)) u_expand (
    .insn16_i (trap_i.insn[15:0]),
    .insn32_o (exp_insn),
    .valid_o  (exp_ok)
  );

  assign full_insn = trap_i.compressed ? exp_insn : trap_i.insn;
  assign addr_diff = trap_i.fault_va - trap_i.orig_va;
  assign addr_off  = addr_diff[4:0];

  trap_xform u_xform (
    .insn_i   (full_insn),
    .offset_i (addr_off),
    .value_o  (xf_val)
  );

  // compressed forms read 01 in the low bits, full forms 11
  assign std_val = (trap_i.compressed && xf_val != 32'h0)
                 ? {xf_val[31:2], 1'h0, xf_val[0]} : xf_val;

  assign gpage_cause = (trap_i.cause == CS_IF_GPAGE) || (trap_i.cause == CS_LD_GPAGE)
                     || (trap_i.cause == CS_ST_GPAGE);
  assign mem_cause   = (trap_i.cause == CS_LD_MISAL) || (trap_i.cause == CS_LD_ACC)
                     || (trap_i.cause == CS_ST_MISAL) || (trap_i.cause == CS_ST_ACC)
                     || (trap_i.cause == CS_LD_PAGE) || (trap_i.cause == CS_ST_PAGE)
                     || (trap_i.cause == CS_LD_GPAGE) || (trap_i.cause == CS_ST_GPAGE);
  assign pseudo_case  = gpage_cause & trap_i.implicit_gs & trap_i.gpa_nonzero;
  assign pseudo_write = trap_i.ad_update & ctrl[CTRL_AD_UPD];
  assign pseudo_val   = ctrl[CTRL_WIDE64]
                      ? (pseudo_write ? PSEUDO_WR64 : PSEUDO_RD64)
                      : (pseudo_write ? PSEUDO_WR32 : PSEUDO_RD32);

  assign next_tinst = trap_i.interrupt ? 32'h0 :
                      pseudo_case      ? pseudo_val :
                      mem_cause        ? std_val : 32'h0;
  assign trap_m  = trap_i.valid & (trap_i.target == TGT_M);
  assign trap_hs = trap_i.valid & (trap_i.target == TGT_HS);

  // ==========================================================================
  // trap return decode and sequencing
  logic [31:0] machine_trap_return_code;
  logic [31:0] super_trap_return_code;
  logic        do_machine_trap_return;
  logic        do_super_trap_return;
  logic        do_super_trap_return_vs;
  logic        do_super_trap_return_hs;

  assign machine_trap_return_code  = {F7_MACHINE_RET, RS2_RET, 5'h00, F3_PRIV, 5'h00, OP_SYSTEM};
  assign super_trap_return_code  = {F7_SUPER_RET, RS2_RET, 5'h00, F3_PRIV, 5'h00, OP_SYSTEM};
  // returns from a too-low privilege are left to the illegal-instruction path
  assign do_machine_trap_return    = ret_i.valid && ret_i.insn == machine_trap_return_code && status.priv == PRIV_M;
  assign do_super_trap_return    = ret_i.valid && ret_i.insn == super_trap_return_code && status.priv != PRIV_U;
  assign do_super_trap_return_vs = do_super_trap_return & status.virt;
  assign do_super_trap_return_hs = do_super_trap_return & ~status.virt;

  always_comb begin
    next_status   = hit_status && wb_wr ? status_t'(status_wr[14:0]) : status;
    next_redirect = 1'h0;
    next_pc       = redirect_pc_o;
    if (do_machine_trap_return) begin
      next_status.priv = status.machine_prev_priv;
      next_status.virt = (status.machine_prev_priv != PRIV_M) & status.machine_prev_virt;
      next_status.machine_prev_virt       = 1'h0;
      next_status.machine_prev_priv       = PRIV_U;
      next_status.machine_irq_enable      = status.machine_prev_irq_enable;
      next_status.machine_prev_irq_enable = 1'h1;
      next_redirect = 1'h1;
      next_pc       = mepc;
    end else if (do_super_trap_return_hs) begin
      next_status.priv = status.super_prev_priv ? PRIV_S : PRIV_U;
      next_status.virt = status.hyp_saved_virt;
      next_status.hyp_saved_virt        = 1'h0;
      next_status.super_prev_priv       = 1'h0;
      next_status.super_irq_enable      = status.super_prev_irq_enable;
      next_status.super_prev_irq_enable = 1'h1;
      next_redirect = 1'h1;
      next_pc       = sepc;
    end else if (do_super_trap_return_vs) begin
      next_status.priv    = status.vs_spp ? PRIV_S : PRIV_U;
      next_status.vs_spp  = 1'h0;
      next_status.vs_sie  = status.vs_super_prev_irq_enable;
      next_status.vs_super_prev_irq_enable = 1'h1;
      next_redirect = 1'h1;
      next_pc       = vsepc;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? next_rdata : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl  <= CTRL_RESET;
      mepc  <= EPC_RESET;
      sepc  <= EPC_RESET;
      vsepc <= EPC_RESET;
    end else if (wb_wr) begin
      if (hit_ctrl)  ctrl  <= ctrl_wr[1:0];
      if (hit_mepc)  mepc  <= merge(mepc, wb_dat_i, wb_sel_i);
      if (hit_sepc)  sepc  <= merge(sepc, wb_dat_i, wb_sel_i);
      if (hit_vsepc) vsepc <= merge(vsepc, wb_dat_i, wb_sel_i);
    end
  end

  // tinst registers hold real state, written in the trap-entry cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mtinst_o    <= TINST_RESET;
      htinst_o    <= TINST_RESET;
      mtinst_we_o <= 1'h0;
      htinst_we_o <= 1'h0;
    end else begin
      mtinst_we_o <= trap_m;
      htinst_we_o <= trap_hs;
      if (trap_m)  mtinst_o <= next_tinst;
      if (trap_hs) htinst_o <= next_tinst;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status        <= STATUS_RESET;
      redirect_o    <= 1'h0;
      redirect_pc_o <= EPC_RESET;
    end else begin
      status        <= next_status;
      redirect_o    <= next_redirect;
      redirect_pc_o <= next_pc;
    end
  end

  assign status_o = status;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic plain_m;
  assign plain_m = trap_m & ~trap_i.interrupt & ~pseudo_case & mem_cause;

  sequence machine_trap_return_fire;
    do_machine_trap_return;
  endsequence
  sequence machine_trap_return_done;
    status.machine_prev_priv == PRIV_U && !status.machine_prev_virt
      && status.machine_prev_irq_enable && redirect_o;
  endsequence
  sequence super_trap_return_hs_fire;
    do_super_trap_return_hs && !hit_status;
  endsequence
  sequence super_trap_return_hs_done;
    !status.hyp_saved_virt && !status.super_prev_priv && status.super_prev_irq_enable
      && redirect_o && redirect_pc_o == $past(sepc);
  endsequence

  irq_zero_a: assert property (trap_m && trap_i.interrupt |=> mtinst_o == 32'h0)
    else $error("interrupt trap left nonzero tinst");
  pseudo_nonzero_a: assert property (
    trap_m && !trap_i.interrupt && pseudo_case |=> mtinst_o != 32'h0 && mtinst_o[1:0] == 2'h0)
    else $error("pseudoinstruction case wrote zero or bad low bits");
  pseudo_width_a: assert property (
    trap_m && !trap_i.interrupt && pseudo_case && !ctrl[CTRL_WIDE64] && !pseudo_write
    |=> mtinst_o == PSEUDO_RD32)
    else $error("32-bit read pseudo code wrong");
  pseudo_wide_a: assert property (
    trap_hs && !trap_i.interrupt && pseudo_case && ctrl[CTRL_WIDE64] && pseudo_write
    |=> htinst_o == PSEUDO_WR64)
    else $error("64-bit write pseudo code wrong");
  pseudo_noad_a: assert property (
    trap_m && !trap_i.interrupt && pseudo_case && !trap_i.ad_update |=> !mtinst_o[5])
    else $error("write pseudo code without A/D update");
  comp_bits_a: assert property (
    plain_m && trap_i.compressed && exp_ok |=> mtinst_o[1:0] == 2'h1)
    else $error("compressed transform low bits not 01");
  full_bits_a: assert property (
    plain_m && !trap_i.compressed && trap_i.insn[6:0] == OP_LOAD |=> mtinst_o[1:0] == 2'h3
      && mtinst_o[31:20] == 12'h000)
    else $error("full load transform wrong");
  amo_keep_a: assert property (
    plain_m && !trap_i.compressed && trap_i.insn[6:0] == OP_AMO
    |=> mtinst_o[31:20] == $past(trap_i.insn[31:20]) && mtinst_o[14:0] == $past(trap_i.insn[14:0])
      && mtinst_o[19:15] == $past(addr_diff[4:0]))
    else $error("atomic transform changed a kept field");
  trap_strobe_a: assert property (trap_m |=> mtinst_we_o && !htinst_we_o)
    else $error("tinst strobe not in trap cycle");
  machine_trap_return_seq_a: assert property (machine_trap_return_fire ##0 !hit_status |=> machine_trap_return_done)
    else $error("machine return sequence wrong");
  super_trap_return_seq_a: assert property (super_trap_return_hs_fire |=> super_trap_return_hs_done)
    else $error("super return sequence wrong");
  super_trap_return_vs_a: assert property (
    do_super_trap_return_vs && !hit_status |=> status.virt && !status.vs_spp && status.vs_super_prev_irq_enable
      && redirect_pc_o == $past(vsepc) && $stable(status.hyp_saved_virt))
    else $error("guest super return sequence wrong");
  wb_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack held two cycles");

endmodule // trap_inst_unit

/* File: test/trap_src_model.sv */
// pipeline-side model: launches one trap request per go pulse
// assumes go_i and req_i change just after a rising edge of clk_i
`timescale 1ns/1ps
module trap_src_model import trap_inst_pkg::*; (
  input  wire logic      clk_i,
  input  wire logic      go_i,
  input  wire trap_req_t req_i,
  output trap_req_t      trap_o
);
  // ==========================================================================
  // request launch
  trap_req_t next_trap;
  initial trap_o = '0;
  always @(posedge clk_i) begin
    // released fields do not hold their last value
    next_trap       = go_i ? req_i : ~trap_o;
    next_trap.valid = go_i;
    trap_o <= next_trap;
  end
endmodule // trap_src_model

/* File: test/tb_trap_inst_unit.sv */
// self-checking bench for the trap instruction unit
// assumes a 10 MHz core clock and a pipeline model driving the trap port
`timescale 1ns/1ps
module tb_trap_inst_unit import trap_inst_pkg::*; ();
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0;
  logic [7:0]  adr = '0, ofs;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = '0, q, x, y, e, pc, ins, wb_dat_o, mtinst_o, htinst_o, redirect_pc_o;
  logic [4:0]  off;
  logic [2:0]  f3;
  logic [11:0] hi;
  logic        wb_ack_o, mtinst_we_o, htinst_we_o, redirect_o;
  trap_req_t   req = '0, r, trap;
  ret_req_t    ret = '0;
  status_t     status_o, s;
  integer      num_errors = 0, total_checks = 0, seed = 32'h9e69a730;
  logic [5:0]  mc [8] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h0D, 6'h0F, 6'h15, 6'h17};
  logic [5:0]  gc [3] = '{CS_IF_GPAGE, CS_LD_GPAGE, CS_ST_GPAGE};
  localparam logic [31:0] MACHINE_TRAP_RETURN_C = {F7_MACHINE_RET, RS2_RET, 13'h0, OP_SYSTEM};
  localparam logic [31:0] SUPER_TRAP_RETURN_C = {F7_SUPER_RET, RS2_RET, 13'h0, OP_SYSTEM};

  trap_inst_unit #(.CORE_RV64(1'h0)) i_trap_inst_unit (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trap_i(trap), .ret_i(ret),
    .mtinst_o(mtinst_o), .htinst_o(htinst_o), .mtinst_we_o(mtinst_we_o),
    .htinst_we_o(htinst_we_o), .status_o(status_o), .redirect_o(redirect_o),
    .redirect_pc_o(redirect_pc_o));
  trap_src_model i_trap_src_model (.clk_i(clk_i), .go_i(go), .req_i(req), .trap_o(trap));

  always #50 clk_i = ~clk_i;

  // ==========================================================================
  // checking and closing
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task hang(input int n);
    if (n >= 8) begin
      num_errors++;
      give_verdict;
    end
  endtask

  // ==========================================================================
  // bus, trap and return cycles, each entered just after a rising edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 8);
    q = wb_dat_o;
    cyc <= 0; stb <= 0;
    hang(n);
    @(posedge clk_i);
  endtask
  task trap_chk(input trap_req_t t, input logic [31:0] v);
    int n;
    go <= 1; req <= t;
    @(posedge clk_i); go <= 0;
    n = 0;
    do begin @(posedge clk_i); n++; end
    while (mtinst_we_o !== 1'b1 && htinst_we_o !== 1'b1 && n < 8);
    hang(n);
    chk(t.target == TGT_HS ? htinst_o : mtinst_o, v);
  endtask
  task ret_chk(input logic [31:0] i, input status_t es, input logic [31:0] p);
    int n;
    ret <= '{valid: 1'h1, insn: i};
    @(posedge clk_i); ret <= '0;
    n = 0;
    do begin @(posedge clk_i); n++; end while (redirect_o !== 1'b1 && n < 8);
    hang(n);
    chk({17'h0, status_o}, {17'h0, es});
    chk(redirect_pc_o, p);
  endtask

  // ==========================================================================
  // expected status after a return
  function automatic status_t x_ret(status_t a, bit m);
    status_t t = a;
    if (m) begin
      t.priv = a.machine_prev_priv;
      t.virt = (a.machine_prev_priv != PRIV_M) & a.machine_prev_virt;
      t.machine_irq_enable = a.machine_prev_irq_enable;
      t.machine_prev_irq_enable = 1'h1;
      t.machine_prev_priv = PRIV_U;
      t.machine_prev_virt = 1'h0;
    end else if (a.virt) begin
      t.priv = a.vs_spp ? PRIV_S : PRIV_U;
      t.vs_sie = a.vs_super_prev_irq_enable;
      t.vs_super_prev_irq_enable = 1'h1;
      t.vs_spp = 1'h0;
    end else begin
      t.priv = a.super_prev_priv ? PRIV_S : PRIV_U;
      t.virt = a.hyp_saved_virt;
      t.super_irq_enable = a.super_prev_irq_enable;
      t.super_prev_irq_enable = 1'h1;
      t.super_prev_priv = 1'h0;
      t.hyp_saved_virt = 1'h0;
    end
    return t;
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, OFS_STATUS, 32'h0);
    chk(q, {17'h0, STATUS_RESET});
    wb(0, 8'h1C, 32'h0);
    chk(q, 32'h0);
    $display("test reset_map done");
    for (int c = 0; c < 4; c++) for (int a = 0; a < 2; a++) begin
      wb(1, OFS_CTRL, 32'(c));
      r = '0;
      r.cause = gc[(c + a) % 3];
      r.implicit_gs = 1;
      r.gpa_nonzero = 1;
      r.ad_update = a[0];
      r.target = a[0] ? TGT_HS : TGT_M;
      r.insn = $random(seed);
      trap_chk(r, (c[0] ? PSEUDO_RD64 : PSEUDO_RD32) | {26'h0, a[0] & c[1], 5'h0});
    end
    $display("test pseudo done");
    for (int i = 0; i < 60; i++) begin
      x = $random(seed);
      y = $random(seed);
      off = (i == 0) ? 5'h1F : y[4:0];
      f3 = x[13] ? F3_WORD : {2'h0, x[12]};
      r = '0;
      r.cause = mc[y[7:5]];
      r.target = y[8] ? TGT_HS : TGT_M;
      r.orig_va = $random(seed);
      r.fault_va = r.orig_va + 32'(off);
      hi = x[31] ? {7'h35, y[24:20]} : {7'h34, 5'h0};
      case (i % 6)
        0: begin ins = {x[31:15], f3, x[11:7], OP_LOAD}; e = {12'h0, off, f3, x[11:7], OP_LOAD}; end
        1: begin ins = {x[31:25], y[24:20], x[19:15], f3, x[11:7], OP_STORE};
          e = {7'h0, y[24:20], off, f3, 5'h0, OP_STORE}; end
        2: begin ins = {x[31:15], F3_WORD, x[11:7], OP_AMO}; e = {x[31:20], off, F3_WORD, x[11:7], OP_AMO}; end
        3: begin ins = {hi, x[19:15], F3_GUEST, x[31] ? 5'h0 : x[11:7], OP_SYSTEM};
          e = {hi, off, F3_GUEST, ins[11:0]}; end
        default: begin
          r.compressed = 1;
          ins = {y[31:16], x[31], 2'h2, x[12:2], C_QUAD0};
          e = x[31] ? {7'h0, 2'h1, x[4:2], off, F3_WORD, 5'h0, 7'h21}
                    : {12'h0, off, F3_WORD, 2'h1, x[4:2], 7'h01};
        end
      endcase
      r.insn = ins;
      trap_chk(r, e);
    end
    r.target = TGT_M;
    r.interrupt = 1;
    trap_chk(r, 32'h0);
    r.interrupt = 0;
    r.cause = 6'h02;
    trap_chk(r, 32'h0);
    r.cause = CS_LD_ACC;
    r.compressed = 0;
    r.insn = {x[31:7], 7'h13};
    trap_chk(r, 32'h0);
    wb(1, OFS_MTINST, $random(seed));
    wb(0, OFS_MTINST, 32'h0);
    chk(q, 32'h0);
    $display("test transform done");
    for (int i = 0; i < 15; i++) begin
      x = $random(seed);
      pc = $random(seed);
      s = status_t'(x[14:0]);
      s.machine_prev_priv = x[16] ? PRIV_M : (x[15] ? PRIV_S : PRIV_U);
      s.virt = (i % 3 == 2);
      s.priv = (i % 3 == 1 && x[17]) || i % 3 == 0 ? PRIV_M : PRIV_S;
      ofs = (i % 3 == 0) ? OFS_MEPC : (i % 3 == 1 ? OFS_SEPC : OFS_VSEPC);
      wb(1, ofs, pc);
      wb(1, OFS_STATUS, {17'h0, s});
      ret_chk(i % 3 == 0 ? MACHINE_TRAP_RETURN_C : SUPER_TRAP_RETURN_C, x_ret(s, i % 3 == 0), pc);
    end
    ret <= '{valid: 1'h1, insn: {7'h38, RS2_RET, 13'h0, OP_SYSTEM}};
    @(posedge clk_i);
    ret <= '0;
    repeat (3) begin @(posedge clk_i); chk({31'h0, redirect_o}, 32'h0); end
    $display("test returns done");
    give_verdict;
  end
endmodule // tb_trap_inst_unit
